// ---- hw/trgout_defines.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 25 MHz system clock, 8-bit byte address, 32-bit data
// Notes:   Byte addresses are word aligned
`ifndef TRGOUT_DEFINES_SVH
`define TRGOUT_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////
// Clock figures
`define TRGOUT_CLK_HZ          25000000
`define TRGOUT_FAST_PORT_HZ    56250000
`define TRGOUT_SLOW_PORT_HZ    50000000
`define TRGOUT_EXT_MIN_HZ      1
`define TRGOUT_EXT_MAX_HZ      56250000

// Port clock selection codes
`define TRGOUT_CKSEL_FAST      2'h0
`define TRGOUT_CKSEL_EXT       2'h1
`define TRGOUT_CKSEL_SLOW      2'h2

////////////////////////////////////////////////////////////////////////////
// Minimum pulse width ceiling, 0.149 s
`define TRGOUT_WIDTH_MAX_MS    149
`define TRGOUT_WIDTH_MAX_CYC   (`TRGOUT_WIDTH_MAX_MS * (`TRGOUT_CLK_HZ / 1000))

// Fine delay, 0 ps to 2400 ps in 78 ps steps
`define TRGOUT_FINE_MAX_PS     2400
`define TRGOUT_FINE_STEP_PS    78
`define TRGOUT_FINE_MAX_CODE   (`TRGOUT_FINE_MAX_PS / `TRGOUT_FINE_STEP_PS)

////////////////////////////////////////////////////////////////////////////
// Register byte addresses
`define TRGOUT_A_CTRL          8'h00
`define TRGOUT_A_PORT_OUT      8'h04
`define TRGOUT_A_PORT_IN       8'h08
`define TRGOUT_A_TRIG_STAT     8'h0c
`define TRGOUT_A_GEN_DLY       8'h10
`define TRGOUT_A_WIDTH         8'h14
`define TRGOUT_A_CH_BASE       4'h2

// Field positions
`define TRGOUT_CTRL_CKSEL_LSB  0
`define TRGOUT_CTRL_PDRV_LSB   2
`define TRGOUT_CTRL_FDRV_LSB   6
`define TRGOUT_CH_SRC_LSB      0
`define TRGOUT_CH_DLY_LSB      8
`define TRGOUT_CH_FINE_LSB     16

// Reset values
`define TRGOUT_CTRL_RST        8'h00
`define TRGOUT_PORT_OUT_RST    32'h0000_0000

`endif

// ---- hw/trgout_pkg.sv ----
// Purpose: Types shared by the trigger output routing block
// Assumes: Source codes follow the enum order, 0 upward
// Notes:   Codes above the last source read as off
package trgout_pkg;

  // Trigger output source selector
  typedef enum logic [4:0] {
    SRC_OFF, SRC_OSC_PHASE,
    SRC_SCOPE_TRIG, SRC_SCOPE_TRIG_N,
    SRC_SCOPE_ARMED, SRC_SCOPE_ARMED_N,
    SRC_SCOPE_ACTIVE, SRC_SCOPE_ACTIVE_N,
    SRC_MARKER1, SRC_MARKER2, SRC_MARKER3, SRC_MARKER4,
    SRC_GEN_ACTIVE, SRC_GEN_WAITING, SRC_GEN_FETCHING, SRC_GEN_PLAYING,
    SRC_SEQ1, SRC_SEQ2, SRC_SEQ3, SRC_SEQ4,
    SRC_SYNC_CLK, SRC_SYNC_SIG
  } trgout_src_e;

  typedef logic [21:0] trgout_width_t;
  typedef logic [4:0]  trgout_fine_t;
  typedef logic [3:0]  trgout_dly_t;

endpackage : trgout_pkg

// ---- hw/trgout_chan.sv ----
// Purpose: One trigger output: source pick, stretch, coarse delay
// Assumes: Event inputs are on clk; dly is at most 31
// Notes:   Output is blanked one cycle on any source change
`timescale 1ns/1ps
module trgout_chan (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire trgout_pkg::trgout_src_e   src,
  input  wire trgout_pkg::trgout_width_t width,
  input  wire logic [4:0]             dly,
  input  wire logic                   osc_msb,
  input  wire logic [2:0]             scope,
  input  wire logic [3:0]             gen,
  input  wire logic [3:0]             marker,
  input  wire logic [3:0]             seq,
  input  wire logic [1:0]             sync,
  output logic                        trig_out
);
  import trgout_pkg::*;

  trgout_src_e   cur_src_reg;
  trgout_width_t cnt_reg;
  logic          blank_reg, osc_prev_reg, ev_prev_reg;
  logic [31:0]   dly_reg;
  logic          ev, inv, strt, pre;

  ////////////////////////////////////////////////////////////////////////
  // Adopt a new source behind one blank cycle so no runt escapes
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_src_reg <= SRC_OFF;
      blank_reg   <= 1'b0;
    end else if (src != cur_src_reg) begin
      cur_src_reg <= src;
      blank_reg   <= 1'b1;
    end else begin
      blank_reg   <= 1'b0;
    end
  end

  // Previous values for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_prev_reg <= 1'b0;
      ev_prev_reg  <= 1'b0;
    end else begin
      osc_prev_reg <= osc_msb;
      ev_prev_reg  <= ev;
    end
  end

  // Source pick; phase rising through zero is sign bit falling
  always_comb begin
    ev   = 1'b0;
    inv  = 1'b0;
    strt = 1'b0;
    case (cur_src_reg)
      SRC_OSC_PHASE:      ev = osc_prev_reg & ~osc_msb;
      SRC_SCOPE_TRIG:     begin ev = scope[0]; strt = 1'b1; end
      SRC_SCOPE_TRIG_N:   begin ev = scope[0]; strt = 1'b1; inv = 1'b1; end
      SRC_SCOPE_ARMED:    ev = scope[1];
      SRC_SCOPE_ARMED_N:  begin ev = scope[1]; inv = 1'b1; end
      SRC_SCOPE_ACTIVE:   begin ev = scope[2]; strt = 1'b1; end
      SRC_SCOPE_ACTIVE_N: begin ev = scope[2]; strt = 1'b1; inv = 1'b1; end
      SRC_MARKER1:        ev = marker[0];
      SRC_MARKER2:        ev = marker[1];
      SRC_MARKER3:        ev = marker[2];
      SRC_MARKER4:        ev = marker[3];
      SRC_GEN_ACTIVE:     begin ev = gen[0]; strt = 1'b1; end
      SRC_GEN_WAITING:    ev = gen[1];
      SRC_GEN_FETCHING:   ev = gen[2];
      SRC_GEN_PLAYING:    ev = gen[3];
      SRC_SEQ1:           begin ev = seq[0]; strt = 1'b1; end
      SRC_SEQ2:           begin ev = seq[1]; strt = 1'b1; end
      SRC_SEQ3:           begin ev = seq[2]; strt = 1'b1; end
      SRC_SEQ4:           begin ev = seq[3]; strt = 1'b1; end
      SRC_SYNC_CLK:       ev = sync[0];
      SRC_SYNC_SIG:       ev = sync[1];
      default:            ev = 1'b0;
    endcase
  end

  // Stretch counter reloads on each rising event of a stretched source
  always_ff @(posedge clk) begin
    if (rst || blank_reg) begin
      cnt_reg <= '0;
    end else if (strt && ev && !ev_prev_reg) begin
      cnt_reg <= (width == '0) ? '0 : width - 22'h1;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 22'h1;
    end
  end

  assign pre = ~blank_reg & (inv ^ (ev | (strt & (cnt_reg != '0))));

  // Delay line; tap 0 bypasses it
  always_ff @(posedge clk) begin
    if (rst) begin
      dly_reg  <= '0;
      trig_out <= 1'b0;
    end else begin
      dly_reg  <= {dly_reg[30:0], pre};
      trig_out <= (dly == 5'h0) ? pre : dly_reg[dly - 5'h1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_off_quiet: assert property (@(posedge clk) disable iff (rst)
    cur_src_reg == SRC_OFF |-> !pre) else $error("off source not low");
  a_switch_gap: assert property (@(posedge clk) disable iff (rst)
    src != cur_src_reg |=> !pre) else $error("no gap on source change");
  a_stretch_hold: assert property (@(posedge clk) disable iff (rst)
    (strt && !inv && !blank_reg && ev && !ev_prev_reg && width == 22'h4
     && src == cur_src_reg) |=> (pre && cnt_reg == 22'h3))
    else $error("pulse not stretched");
  a_delay_tap: assert property (@(posedge clk) disable iff (rst)
    dly == 5'h5 |=> trig_out == $past(pre, 6)) else $error("delay wrong");
  c_stretch: cover property (@(posedge clk) disable iff (rst)
    strt && !ev && cnt_reg != '0);

endmodule : trgout_chan

// ---- hw/trgout_top.sv ----
// Purpose: Trigger output routing, trigger input status, port control
// Assumes: Single 25 MHz clock, synchronous active-high reset
// Notes:   Event inputs from the scope and generator are on clk
//          Clock mux and delay cells are outside
//
// Summary of operation
// - Fast internal code selects 56.25 MHz port clock
// - Pin clock, 1 Hz-56.25 MHz; the pin rate is not checked here
// - Slow internal code selects 50 MHz port clock
// - Each trigger input reports low and high flags
// - Source off keeps the output deasserted
// - Phase zero crossings; ch1 demod 4, ch2 8
// - Scope trigger source, plus inverted variant
// - Scope armed source, plus inverted variant
// - Scope active source, plus inverted variant
// - Four waveform marker sources
// - Generator active source follows generator enable
// - Generator waiting source
// - Generator fetching source
// - Generator playing source
// - Four sequencer trigger sources
// - Sync clock source drives the output
// - Sync signal source drives the output
// - Output delay is channel offset plus general delay
// - Scope trigger, scope active, generator active and sequencer events stretched to programmable width
// - Fine delay to 2.4 ns, 78 ps steps
// - Front connector drive selects output or input
// - Port split into four 8-bit buses with drive
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "trgout_defines.svh"
module trgout_top #(
  parameter int WIDTH_MAX_CYC = `TRGOUT_WIDTH_MAX_CYC
) (
  // Clock, reset and register port
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,

  // Trigger pins and front drives
  input  wire logic [1:0]  trig_pad_in,
  input  wire logic [1:0]  trig_back_in,
  output logic [3:0]       trig_out,
  output logic [1:0]       trig_pad_oe_n,

  // Digital port and its clock pick
  input  wire logic [31:0] port_in,
  output logic [31:0]      port_out,
  output logic [31:0]      port_oe_n,
  output logic [1:0]       port_clk_sel,
  output logic [19:0]      fine_dly,

  // Event sources, all on clk
  input  wire logic        osc_d4_msb,
  input  wire logic        osc_d8_msb,
  input  wire logic        scope_trig,
  input  wire logic        scope_armed,
  input  wire logic        scope_active,
  input  wire logic        gen_active,
  input  wire logic        gen_waiting,
  input  wire logic        gen_fetching,
  input  wire logic        gen_playing,
  input  wire logic [3:0]  marker,
  input  wire logic [3:0]  seq_trig,
  input  wire logic        sync_clk,
  input  wire logic        sync_sig
);
  import trgout_pkg::*;

  localparam int NCH = 4;
  localparam trgout_width_t WMAX = trgout_width_t'(WIDTH_MAX_CYC);
  localparam trgout_fine_t FMAX = trgout_fine_t'(`TRGOUT_FINE_MAX_CODE);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]    ctrl_reg;
  logic [31:0]   pout_reg;
  trgout_dly_t   gdly_reg;
  trgout_width_t width_reg;
  trgout_src_e   src_reg  [NCH];
  trgout_dly_t   cdly_reg [NCH];
  trgout_fine_t  fine_reg [NCH];

  // Pin pipeline and status
  logic [35:0]   s1_reg, s2_reg, s3_reg;
  logic [35:0]   filt_reg;
  logic [3:0]    trig_hi_reg, trig_lo_reg;

  // Bus side and pin drives
  logic [31:0]   rdata_reg;
  logic [31:0]   poe_n_reg;
  logic [1:0]    fdrv_n_reg;
  logic          ch_hit;
  logic [1:0]    ch_idx;

  // Channel words at 20 to 2c, word aligned
  assign ch_hit = (addr[7:4] == `TRGOUT_A_CH_BASE) && (addr[1:0] == 2'h0);
  assign ch_idx = addr[3:2];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: three stages, only stage two feeds stage three
  // One pipeline for port and trigger pins
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= {trig_back_in, trig_pad_in, port_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit counts once stages two and three agree; rejects one-cycle noise
  // Costs four edges of latency per pin
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_reg <= '0;
    end else begin
      for (int i = 0; i < 36; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          filt_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // Trigger input state flags, one pair per input
  // Level only; thresholds live outside
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_hi_reg <= '0;
      trig_lo_reg <= '0;
    end else begin
      trig_hi_reg <= filt_reg[35:32];
      trig_lo_reg <= ~filt_reg[35:32];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control word: port clock, bus drives, front drives
  // All eight bits read back as written
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= `TRGOUT_CTRL_RST;
    end else if (wr && addr == `TRGOUT_A_CTRL) begin
      ctrl_reg <= wdata[7:0];
    end
  end

  // Clock pick leaves here; the clock mux sits outside this block
  // A change mid-transfer is the user's risk
  always_ff @(posedge clk) begin
    if (rst) begin
      port_clk_sel <= `TRGOUT_CKSEL_FAST;
    end else begin
      // Fast, pin or slow source; pin rate is the far end's job
      port_clk_sel <= ctrl_reg[`TRGOUT_CTRL_CKSEL_LSB +: 2];
    end
  end

  // Drive enables are active low at the pins
  // Reset leaves every pin an input
  always_ff @(posedge clk) begin
    if (rst) begin
      poe_n_reg  <= '1;
      fdrv_n_reg <= '1;
    end else begin
      for (int b = 0; b < 4; b++) begin
        poe_n_reg[b*8 +: 8] <=
          {8{~ctrl_reg[`TRGOUT_CTRL_PDRV_LSB + b]}};
      end
      fdrv_n_reg <= ~ctrl_reg[`TRGOUT_CTRL_FDRV_LSB +: 2];
    end
  end

  // Enables leave straight from flops
  assign port_oe_n     = poe_n_reg;
  assign trig_pad_oe_n = fdrv_n_reg;

  // Manual port output value
  // Reaches only buses whose drive is on
  always_ff @(posedge clk) begin
    if (rst) begin
      pout_reg <= `TRGOUT_PORT_OUT_RST;
    end else if (wr && addr == `TRGOUT_A_PORT_OUT) begin
      pout_reg <= wdata;
    end
  end

  // Value holds until the next write
  assign port_out = pout_reg;

  ////////////////////////////////////////////////////////////////////////
  // General output delay, shared by all channels
  // Whole cycles; fine delay is separate
  always_ff @(posedge clk) begin
    if (rst) begin
      gdly_reg <= '0;
    end else if (wr && addr == `TRGOUT_A_GEN_DLY) begin
      gdly_reg <= wdata[3:0];
    end
  end

  // Minimum width in cycles; clamped so 0.149 s is the ceiling
  // Clamping beats wrapping a large count
  always_ff @(posedge clk) begin
    if (rst) begin
      width_reg <= '0;
    end else if (wr && addr == `TRGOUT_A_WIDTH) begin
      width_reg <= (wdata[21:0] > WMAX) ? WMAX : wdata[21:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel source, delay offset and fine delay code
  // One write sets all three fields
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        src_reg[c]  <= SRC_OFF;
        cdly_reg[c] <= '0;
        fine_reg[c] <= '0;
      end
    end else if (wr && ch_hit) begin
      // Unknown source codes fall to off in the channel
      src_reg[ch_idx]  <= trgout_src_e'(wdata[4:0]);
      cdly_reg[ch_idx] <= wdata[`TRGOUT_CH_DLY_LSB +: 4];
      // Codes past 2.4 ns clamp to the last step
      fine_reg[ch_idx] <=
        (wdata[`TRGOUT_CH_FINE_LSB +: 5] > FMAX)
        ? FMAX : wdata[`TRGOUT_CH_FINE_LSB +: 5];
    end
  end

  // Fine delay codes go to the analog delay cells
  // Five bits each, channel 1 lowest
  assign fine_dly = {fine_reg[3], fine_reg[2], fine_reg[1], fine_reg[0]};

  ////////////////////////////////////////////////////////////////////////
  // Read port: data stand only in the cycle after the strobe
  // Zero otherwise, so nothing stale shows
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata_reg <= '0;
    end else if (ch_hit) begin
      rdata_reg <= {11'h0, fine_reg[ch_idx], 4'h0, cdly_reg[ch_idx],
                    3'h0, src_reg[ch_idx]};
    end else begin
      case (addr)
        `TRGOUT_A_CTRL:      rdata_reg <= {24'h0, ctrl_reg};
        `TRGOUT_A_PORT_OUT:  rdata_reg <= pout_reg;
        `TRGOUT_A_PORT_IN:   rdata_reg <= filt_reg[31:0];
        `TRGOUT_A_TRIG_STAT: rdata_reg <= {24'h0, trig_lo_reg, trig_hi_reg};
        `TRGOUT_A_GEN_DLY:   rdata_reg <= {28'h0, gdly_reg};
        `TRGOUT_A_WIDTH:     rdata_reg <= {10'h0, width_reg};
        default:             rdata_reg <= '0;
      endcase
    end
  end

  // Registered, so no path from addr to rdata
  assign rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Trigger output channels; odd channels follow demod 4, even demod 8
  // Each channel keeps its own state
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [4:0] tot_dly;

    // Channel offset added to the shared delay
    // Sum fits five bits, at most 30 cycles
    assign tot_dly = {1'b0, cdly_reg[g]} + {1'b0, gdly_reg};

    trgout_chan u_chan (
      .clk      (clk),
      .rst      (rst),
      .src      (src_reg[g]),
      .width    (width_reg),
      .dly      (tot_dly),
      .osc_msb  ((g % 2 == 0) ? osc_d4_msb : osc_d8_msb),
      .scope    ({scope_active, scope_armed, scope_trig}),
      .gen      ({gen_playing, gen_fetching, gen_waiting, gen_active}),
      .marker   (marker),
      .seq      (seq_trig),
      .sync     ({sync_sig, sync_clk}),
      .trig_out (trig_out[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the register side and pin control
  // Two-edge checks span control and pin flop
  a_clk_pick: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `TRGOUT_A_CTRL |=> ##1 port_clk_sel == $past(wdata[1:0], 2))
    else $error("port clock pick does not follow control");

  a_bus_drive: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `TRGOUT_A_CTRL |=> ##1
      port_oe_n[31:24] == {8{~$past(wdata[5], 2)}} &&
      port_oe_n[7:0] == {8{~$past(wdata[2], 2)}})
    else $error("bus drive does not follow control");

  a_front_drive: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `TRGOUT_A_CTRL |=> ##1
      trig_pad_oe_n == ~$past(wdata[7:6], 2))
    else $error("front drive does not follow control");

  a_in_status: assert property (@(posedge clk) disable iff (rst)
    trig_back_in[1] [*5] |=> trig_hi_reg[3] && !trig_lo_reg[3])
    else $error("trigger input flags wrong");

  a_read_once: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == 32'h0) else $error("read data held too long");

  a_width_cap: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `TRGOUT_A_WIDTH && wdata[21:0] > WMAX |=> width_reg == WMAX)
    else $error("width not clamped");

  a_fine_cap: assert property (@(posedge clk) disable iff (rst)
    fine_dly[4:0] <= FMAX) else $error("fine delay past range");

  a_port_value: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `TRGOUT_A_PORT_OUT |=> port_out == $past(wdata))
    else $error("port output value not taken");

  // Main scenarios
  c_read_stat: cover property (@(posedge clk) disable iff (rst)
    rd && addr == `TRGOUT_A_TRIG_STAT ##1 rdata != 32'h0);
  c_src_change: cover property (@(posedge clk) disable iff (rst)
    wr && ch_hit ##3 trig_out[0]);
  c_ext_clock: cover property (@(posedge clk) disable iff (rst)
    port_clk_sel == `TRGOUT_CKSEL_EXT);

endmodule : trgout_top

// ---- verif/trgout_rx_model.sv ----
// Purpose: Far-side equipment that receives trigger pulses on the outputs
// Assumes: Front pads have a pull-down when nobody drives them
// Notes:   Counts rising edges so that one-cycle pulses are not missed
`timescale 1ns/1ps
module trgout_rx_model (
  input  wire logic       clk,
  input  wire logic [3:0] trig,
  input  wire logic [1:0] pad_oe_n,
  input  wire logic [1:0] ext_drv,
  input  wire logic [1:0] ext_lvl,
  output logic [1:0]      pad,
  output logic [7:0]      cnt_ch1,
  output logic [7:0]      cnt_ch2
);
  logic [1:0] last_reg = 2'h0;
  logic [7:0] c1_reg   = 8'h00;
  logic [7:0] c2_reg   = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Pad level: device, far side, else the pull-down wins
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!pad_oe_n[i]) pad[i] = trig[i];
      else if (ext_drv[i]) pad[i] = ext_lvl[i];
      else pad[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge counters on outputs 1 and 2
  always_ff @(posedge clk) begin
    last_reg <= trig[1:0];
    if (trig[0] && !last_reg[0]) c1_reg <= c1_reg + 8'h01;
    if (trig[1] && !last_reg[1]) c2_reg <= c2_reg + 8'h01;
  end
  assign cnt_ch1 = c1_reg;
  assign cnt_ch2 = c2_reg;
endmodule : trgout_rx_model

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the trigger output routing block
// Assumes: Width ceiling shortened to 20 cycles for a quick run
// Notes:   Port pins are resolved here from the per-bit enables
`timescale 1ns/1ps
module testbench;
  import trgout_pkg::*;
  localparam int WMAX = 20;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, port_in, port_out, port_oe_n;
  logic [31:0] port_ext = 32'h0;
  logic [1:0]  pad, pad_oe_n, port_clk_sel, ext_drv = 2'h0;
  logic [1:0]  ext_lvl = 2'h0, back = 2'h0;
  logic [3:0]  trig_out, marker = 4'h0, seq_trig = 4'h0;
  logic [19:0] fine_dly;
  logic [7:0]  cnt1, cnt2, k1, k2;
  logic osc4 = 1'b0, osc8 = 1'b0, scope_trig = 1'b0, scope_armed = 1'b0;
  logic scope_active = 1'b0, gen_active = 1'b0, gen_waiting = 1'b0;
  logic gen_fetching = 1'b0, gen_playing = 1'b0;
  logic sync_clk = 1'b0, sync_sig = 1'b0;
  logic [31:0] v;
  int fails = 0, cmp_count = 0;

  always #20 clk = ~clk;
  // Undriven port bits fall back to the far side's value
  assign port_in = (port_oe_n & port_ext) | (~port_oe_n & port_out);

  trgout_top #(.WIDTH_MAX_CYC(WMAX)) trgout_top_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trig_pad_in(pad), .trig_back_in(back),
    .trig_out(trig_out), .trig_pad_oe_n(pad_oe_n), .port_in(port_in),
    .port_out(port_out), .port_oe_n(port_oe_n),
    .port_clk_sel(port_clk_sel), .fine_dly(fine_dly), .osc_d4_msb(osc4),
    .osc_d8_msb(osc8), .scope_trig(scope_trig),
    .scope_armed(scope_armed), .scope_active(scope_active),
    .gen_active(gen_active), .gen_waiting(gen_waiting),
    .gen_fetching(gen_fetching), .gen_playing(gen_playing),
    .marker(marker), .seq_trig(seq_trig), .sync_clk(sync_clk),
    .sync_sig(sync_sig));

  trgout_rx_model trgout_rx_model_inst (
    .clk(clk), .trig(trig_out), .pad_oe_n(pad_oe_n), .ext_drv(ext_drv),
    .ext_lvl(ext_lvl), .pad(pad), .cnt_ch1(cnt1), .cnt_ch2(cnt2));

  ////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus helpers
  task automatic check(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitc

  task automatic ch_src(input int ch, input int code);
    wr_reg(8'h20 + 8'(4 * ch), 32'(code));
  endtask : ch_src

  // Drive the event input that a source code selects
  task automatic set_src(input int c, input logic b);
    @(posedge clk);
    case (c)
      2, 3:    scope_trig <= b;
      4, 5:    scope_armed <= b;
      6, 7:    scope_active <= b;
      8, 9, 10, 11:   marker[c-8] <= b;
      12: gen_active <= b;
      13: gen_waiting <= b;
      14: gen_fetching <= b;
      15: gen_playing <= b;
      16, 17, 18, 19: seq_trig[c-16] <= b;
      20: sync_clk <= b;
      21: sync_sig <= b;
      default: ;
    endcase
  endtask : set_src

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rd_reg(8'h00, v);
    check("ctrl", v, 32'h0);
    check("trig_out", {28'h0, trig_out}, 32'h0);
    check("pad_oe_n", {30'h0, pad_oe_n}, 32'h3);
    check("port_oe_n", port_oe_n, 32'hffff_ffff);
    check("fine", {12'h0, fine_dly}, 32'h0);
  endtask : t_reset

  // Clock picks, bus drive groups, port loopback, unmapped read
  task automatic t_ctrl;
    for (int s = 0; s < 3; s++) begin
      wr_reg(8'h00, 32'(s));
      waitc(2);
      check("clk_sel", {30'h0, port_clk_sel}, 32'(s));
    end
    wr_reg(8'h00, 32'h94);
    wr_reg(8'h04, 32'h1234_5678);
    port_ext <= 32'hcafe_f00d;
    waitc(2);
    check("port_oe_n", port_oe_n, 32'hff00_ff00);
    check("pad_oe_n", {30'h0, pad_oe_n}, 32'h1);
    waitc(8);
    rd_reg(8'h08, v);
    check("port_in", v, 32'hca34_f078);
    rd_reg(8'h3c, v);
    check("unmapped", v, 32'h0);
    wr_reg(8'h00, 32'h0);
  endtask : t_ctrl

  // High and low flags, then pads looped back from the device
  task automatic t_status;
    ext_drv <= 2'h3; ext_lvl <= 2'h1; back <= 2'h2;
    waitc(8);
    rd_reg(8'h0c, v);
    check("flags", v, 32'h69);
    wr_reg(8'h00, 32'hc0);
    waitc(8);
    rd_reg(8'h0c, v);
    check("flags_drv", v, 32'h78);
    wr_reg(8'h00, 32'h0);
  endtask : t_status

  // Every source code except phase, both input levels, unused codes act as off
  task automatic t_levels;
    logic inv, off;
    wr_reg(8'h14, 32'h0);
    for (int c = 0; c < 24; c++) begin
      if (c == 1) continue;
      inv = (c == 3 || c == 5 || c == 7);
      off = (c == 0 || c > 21);
      ch_src(0, c);
      waitc(4);
      check("lvl_lo", {31'h0, trig_out[0]}, {31'h0, !off && inv});
      set_src(c, 1'b1);
      waitc(4);
      check("lvl_hi", {31'h0, trig_out[0]}, {31'h0, !off && !inv});
      set_src(c, 1'b0);
    end
  endtask : t_levels

  // One pulse per falling sign bit, each channel on its own demod
  task automatic t_osc;
    ch_src(0, 1);
    ch_src(1, 1);
    for (int d = 0; d < 2; d++) begin
      if (d == 0) osc4 <= 1'b1; else osc8 <= 1'b1;
      waitc(4);
      k1 = cnt1; k2 = cnt2;
      if (d == 0) osc4 <= 1'b0; else osc8 <= 1'b0;
      waitc(4);
      check("osc_ch1", {24'h0, cnt1}, {24'h0, k1 + 8'(d == 0)});
      check("osc_ch2", {24'h0, cnt2}, {24'h0, k2 + 8'(d == 1)});
    end
    ch_src(1, 0);
  endtask : t_osc

  // One-cycle scope trigger held for the programmed width
  task automatic t_stretch(input int w, input int n);
    int h;
    h = 0;
    wr_reg(8'h14, 32'(w));
    ch_src(0, 2);
    waitc(4);
    set_src(2, 1'b1);
    set_src(2, 1'b0);
    repeat (40) begin
      #1 if (trig_out[0] === 1'b1) h++;
      @(posedge clk);
    end
    check("stretch", 32'(h), 32'(n));
  endtask : t_stretch

  // Channel offset 3 plus general delay 2, one cycle of latency
  task automatic t_delay;
    int n;
    n = 0;
    wr_reg(8'h14, 32'h0);
    wr_reg(8'h10, 32'h2);
    wr_reg(8'h20, 32'h0308);
    waitc(8);
    set_src(8, 1'b1);
    while (trig_out[0] !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    check("delay", 32'(n), 32'h6);
    set_src(8, 1'b0);
    wr_reg(8'h10, 32'h0);
  endtask : t_delay

  // Switch between two high sources: exactly one low cycle between
  task automatic t_blank;
    int lows;
    lows = 0;
    ch_src(0, 8);
    set_src(8, 1'b1);
    set_src(9, 1'b1);
    waitc(4);
    check("pre", {31'h0, trig_out[0]}, 32'h1);
    ch_src(0, 9);
    repeat (8) begin
      #1 if (trig_out[0] === 1'b0) lows++;
      @(posedge clk);
    end
    check("blank", 32'(lows), 32'h1);
    check("post", {31'h0, trig_out[0]}, 32'h1);
    wr_reg(8'h28, 32'h9);
    wr_reg(8'h2c, 32'h8);
    waitc(4);
    check("ch34", {30'h0, trig_out[3:2]}, 32'h3);
  endtask : t_blank

  task automatic t_fine;
    wr_reg(8'h20, 32'h0005_0000);
    wr_reg(8'h24, 32'h001f_0000);
    waitc(2);
    check("fine", {22'h0, fine_dly[9:0]}, {22'h0, 5'd30, 5'd5});
  endtask : t_fine

  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    waitc(2);
    t_reset();
    t_ctrl();
    t_status();
    t_levels();
    t_osc();
    t_stretch(4, 4);
    t_stretch(100, WMAX);
    t_delay();
    t_blank();
    t_fine();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule : testbench
